//--- sms_map.svh
// Purpose: Register offsets, field widths and reset values of the move sequencer
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SMS_ADDR_W 6
`define SMS_OFF_CTRL 6'h00
`define SMS_OFF_STATUS 6'h04
`define SMS_OFF_TARGET 6'h08
`define SMS_OFF_SPEED 6'h0c
`define SMS_OFF_START 6'h10
`define SMS_OFF_ACCEL 6'h14
`define SMS_OFF_DECEL 6'h18
`define SMS_OFF_REGSTEPS 6'h1c
`define SMS_OFF_MINREG 6'h20
`define SMS_OFF_POS 6'h24
`define SMS_OFF_ENC 6'h28
// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define SMS_CTRL_W 10
`define SMS_SPD_W 16
`define SMS_ACC_W 24
`define SMS_RST_SPEED 16'h0400
`define SMS_RST_START 16'h0080
`define SMS_RST_RAMP 16'h0008
`endif

//--- sms_pkg.sv
// Purpose: Types shared by the move sequencer
// Assumes: Nothing beyond SystemVerilog
// Notes: Control word travels as a packed struct
package sms_pkg;
    // ****************************************************************
    // Sequencer states and move kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        SMS_IDLE = 2'b00,
        SMS_RUN = 2'b01,
        SMS_DECEL = 2'b10,
        SMS_HELD = 2'b11
    } sms_state_t;

    typedef enum logic [1:0] {
        SMS_MV_NONE = 2'b00,
        SMS_MV_REG = 2'b01,
        SMS_MV_REL = 2'b10,
        SMS_MV_ABS = 2'b11
    } sms_kind_t;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic reg_dir_cw;   // [9] registration direction
        logic enc_mode;     // [8] encoder-controlled moves
        logic preset;       // [7] preset position strobe
        logic err_reset;    // [6] reset errors strobe
        logic imm_stop;     // [5] immediate stop level
        logic resume;       // [4] resume strobe
        logic hold;         // [3] hold, acts on toggle
        logic abs_go;       // [2] absolute start strobe
        logic rel_go;       // [1] relative start strobe
        logic reg_cmd;      // [0] registration command level
    } sms_ctrl_t;
endpackage

//--- sms_sequencer.sv
// Purpose: Move-command sequencer of a stepper indexer with Avalon-MM registers
// Assumes: One 50 MHz clock; all pins are asynchronous and pass two flops
// Notes: Speed is a phase increment; step rate = speed * f_clk / 2^24
// Behaviour
// - Registration command cleared starts controlled stop
// - Stop input active at start: min plus steps
// - Hold in registration: decelerate, no steps, no hold
// - Immediate-stop bit rising stops motion at once
// - E-stop input rising stops motion at once
// - Same-direction limit stops and locks that direction
// - Start allowed opposite an active limit
// - Relative sign sets direction, magnitude sets counts
// - Relative moves allowed with position invalid
// - Hold in relative move stops into held state
// - Absolute direction and counts from target minus position
// - Absolute refused unless position valid
// - Hold in absolute move stops into held state
// - Encoder mode counts encoder, not steps, except registration moves, which count steps
// - Encoder target reached starts deceleration
// - Relative encoder needs no preset, resumable
// - Registration stop emits programmed steps while decelerating
// - Registration stop conditions level, deferred to minimum
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`include "sms_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sms_sequencer (
    input wire logic sys_clk,                     // 50 MHz clock
    input wire logic resetn,                      // Async reset, active low
    input wire logic [`SMS_ADDR_W-1:0] address,   // Avalon byte address
    input wire logic read,                        // Avalon read
    input wire logic write,                       // Avalon write
    input wire logic [31:0] writedata,            // Avalon write data
    output logic [31:0] readdata,                 // Avalon read data
    output logic waitrequest,                     // Avalon wait
    input wire logic estop_in,                    // E-stop input pin
    input wire logic mstop_in,                    // Manual move stop input pin
    input wire logic cw_lim_in,                   // Clockwise limit pin
    input wire logic ccw_lim_in,                  // Counter-clockwise limit pin
    input wire logic enc_a_in,                    // Encoder channel A
    input wire logic enc_b_in,                    // Encoder channel B
    output logic step_out,                        // One-cycle step pulse
    output logic dir_cw_out                       // Direction, high for clockwise
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [5:0] pin_m_q, pin_s_q, pin_p_q;
    // Two flops, then a third stage for edge detection
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_m_q <= 6'h00;
            pin_s_q <= 6'h00;
            pin_p_q <= 6'h00;
        end else begin
            pin_m_q <= {enc_b_in, enc_a_in, ccw_lim_in, cw_lim_in, mstop_in, estop_in};
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end
    logic estop_rise, mstop_lvl, mstop_rise, cw_lim, ccw_lim;
    assign estop_rise = pin_s_q[0] & ~pin_p_q[0];
    assign mstop_lvl = pin_s_q[1];
    assign mstop_rise = pin_s_q[1] & ~pin_p_q[1];
    assign cw_lim = pin_s_q[2];
    assign ccw_lim = pin_s_q[3];

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    logic ack_q;
    logic wr_take;
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_take = write & ack_q;
    // One wait cycle, then the request completes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    sms_pkg::sms_ctrl_t ctrl_q, ctrl_prev_q;
    logic [31:0] target_q, regsteps_q, minreg_q, pos_q, enc_q;
    logic [`SMS_SPD_W-1:0] speed_q, start_q, accel_q, decel_q;
    logic [`SMS_CTRL_W-1:0] wd_ctrl;
    assign wd_ctrl = writedata[`SMS_CTRL_W-1:0];
    // Parameter registers; strobe bits self-clear after one cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= '0;
            target_q <= 32'h0000_0000;
            speed_q <= `SMS_RST_SPEED;
            start_q <= `SMS_RST_START;
            accel_q <= `SMS_RST_RAMP;
            decel_q <= `SMS_RST_RAMP;
            regsteps_q <= 32'h0000_0000;
            minreg_q <= 32'h0000_0000;
        end else begin
            ctrl_q.rel_go <= 1'b0;
            ctrl_q.abs_go <= 1'b0;
            ctrl_q.resume <= 1'b0;
            ctrl_q.err_reset <= 1'b0;
            ctrl_q.preset <= 1'b0;
            if (wr_take) begin
                case (address)
                    `SMS_OFF_CTRL: ctrl_q <= sms_pkg::sms_ctrl_t'(wd_ctrl);
                    `SMS_OFF_TARGET: target_q <= writedata;
                    `SMS_OFF_SPEED: speed_q <= writedata[`SMS_SPD_W-1:0];
                    `SMS_OFF_START: start_q <= writedata[`SMS_SPD_W-1:0];
                    `SMS_OFF_ACCEL: accel_q <= writedata[`SMS_SPD_W-1:0];
                    `SMS_OFF_DECEL: decel_q <= writedata[`SMS_SPD_W-1:0];
                    `SMS_OFF_REGSTEPS: regsteps_q <= writedata;
                    `SMS_OFF_MINREG: minreg_q <= writedata;
                    default: ;
                endcase
            end
        end
    end

    // Previous control word for edge and toggle detection
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_prev_q <= '0;
        end else begin
            ctrl_prev_q <= ctrl_q;
        end
    end
    logic hold_tgl, imm_rise, reg_rise, halt_now;
    assign hold_tgl = ctrl_q.hold ^ ctrl_prev_q.hold;
    assign imm_rise = ctrl_q.imm_stop & ~ctrl_prev_q.imm_stop;
    assign reg_rise = ctrl_q.reg_cmd & ~ctrl_prev_q.reg_cmd;

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    sms_pkg::sms_state_t state_q;
    sms_pkg::sms_kind_t kind_q;
    logic enc_mv_q, pos_valid_q, cw_lock_q, ccw_lock_q, refused_q;
    logic stop_pend_q, reg_tail_q, hold_stop_q;
    logic [31:0] remain_q, travel_q, ramp_steps_q;
    logic [`SMS_SPD_W-1:0] cur_spd_q;
    logic [`SMS_ACC_W-1:0] phase_q;
    logic [`SMS_ACC_W:0] phase_sum;
    logic step_tick, moving, lim_hit, lock_hit;
    logic [31:0] abs_diff, rel_mag, abs_mag;
    logic [1:0] enc_prev_q;
    logic enc_tick;

    assign moving = (state_q == sms_pkg::SMS_RUN) | (state_q == sms_pkg::SMS_DECEL);
    assign phase_sum = {1'b0, phase_q} + {{(`SMS_ACC_W+1-`SMS_SPD_W){1'b0}}, cur_spd_q};
    assign step_tick = moving & phase_sum[`SMS_ACC_W];
    assign lim_hit = moving & (dir_cw_out ? cw_lim : ccw_lim);
    assign lock_hit = moving & (dir_cw_out ? ccw_lim & ~pin_p_q[3] : cw_lim & ~pin_p_q[2]);
    assign halt_now = imm_rise | estop_rise | lim_hit | lock_hit;
    assign abs_diff = target_q - pos_q;
    assign rel_mag = target_q[31] ? (32'h0 - target_q) : target_q;
    assign abs_mag = abs_diff[31] ? (32'h0 - abs_diff) : abs_diff;
    // Encoder count in either direction (one count per A edge)
    assign enc_tick = pin_s_q[4] ^ enc_prev_q[0];

    // Start acceptance: a direction is blocked by its lock or its own active limit
    logic cw_ok, ccw_ok, rel_ok, abs_ok, reg_ok;
    assign cw_ok = ~cw_lock_q & ~cw_lim;
    assign ccw_ok = ~ccw_lock_q & ~ccw_lim;
    assign rel_ok = target_q[31] ? ccw_ok : cw_ok;
    assign abs_ok = pos_valid_q & (abs_diff[31] ? ccw_ok : cw_ok);
    assign reg_ok = ctrl_q.reg_dir_cw ? cw_ok : ccw_ok;

    // Registration stop condition: level of command, latched stop input
    logic reg_stop_cond, min_done;
    assign reg_stop_cond = ~ctrl_q.reg_cmd | stop_pend_q;
    assign min_done = travel_q >= minreg_q;

    // Remaining distance that calls for deceleration (symmetric ramp estimate)
    logic need_decel;
    assign need_decel = enc_mv_q ? (remain_q == 32'h0) : (remain_q <= ramp_steps_q);

    // Main move state machine
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= sms_pkg::SMS_IDLE;
            kind_q <= sms_pkg::SMS_MV_NONE;
            enc_mv_q <= 1'b0;
            dir_cw_out <= 1'b1;
            remain_q <= 32'h0;
            reg_tail_q <= 1'b0;
            hold_stop_q <= 1'b0;
        end else if (halt_now) begin
            state_q <= sms_pkg::SMS_IDLE;
            kind_q <= sms_pkg::SMS_MV_NONE;
        end else begin
            case (state_q)
                sms_pkg::SMS_IDLE: begin
                    reg_tail_q <= 1'b0;
                    hold_stop_q <= 1'b0;
                    enc_mv_q <= ctrl_q.enc_mode;
                    if (reg_rise && reg_ok) begin
                        kind_q <= sms_pkg::SMS_MV_REG;
                        dir_cw_out <= ctrl_q.reg_dir_cw;
                        enc_mv_q <= 1'b0;
                        state_q <= sms_pkg::SMS_RUN;
                    end else if (ctrl_q.rel_go && rel_ok && rel_mag != 32'h0) begin
                        kind_q <= sms_pkg::SMS_MV_REL;
                        dir_cw_out <= ~target_q[31];
                        remain_q <= rel_mag;
                        state_q <= sms_pkg::SMS_RUN;
                    end else if (ctrl_q.abs_go && abs_ok && abs_mag != 32'h0) begin
                        kind_q <= sms_pkg::SMS_MV_ABS;
                        dir_cw_out <= ~abs_diff[31];
                        remain_q <= abs_mag;
                        state_q <= sms_pkg::SMS_RUN;
                    end
                end
                sms_pkg::SMS_RUN: begin
                    if ((enc_mv_q ? enc_tick : step_tick) && kind_q != sms_pkg::SMS_MV_REG) begin
                        remain_q <= remain_q - 32'h1;
                    end
                    if (hold_tgl) begin
                        hold_stop_q <= 1'b1;
                        state_q <= sms_pkg::SMS_DECEL;
                    end else if (kind_q == sms_pkg::SMS_MV_REG) begin
                        if (reg_stop_cond && min_done) begin
                            reg_tail_q <= 1'b1;
                            remain_q <= regsteps_q;
                            state_q <= (regsteps_q == 32'h0) ? sms_pkg::SMS_IDLE
                                                             : sms_pkg::SMS_DECEL;
                        end
                    end else if (need_decel) begin
                        state_q <= sms_pkg::SMS_DECEL;
                    end
                end
                sms_pkg::SMS_DECEL: begin
                    if ((enc_mv_q ? enc_tick : step_tick) && remain_q != 32'h0) begin
                        remain_q <= remain_q - 32'h1;
                    end
                    if (hold_stop_q) begin
                        if (cur_spd_q <= start_q) begin
                            // Registration ends; others park in the held state
                            state_q <= (kind_q == sms_pkg::SMS_MV_REG) ? sms_pkg::SMS_IDLE
                                                                       : sms_pkg::SMS_HELD;
                        end
                    end else if (reg_tail_q || !enc_mv_q) begin
                        // Step count ends the move even if still fast
                        if (remain_q == 32'h0 ||
                            (remain_q == 32'h1 && step_tick)) begin
                            state_q <= sms_pkg::SMS_IDLE;
                        end
                    end else if (cur_spd_q <= start_q) begin
                        state_q <= sms_pkg::SMS_IDLE;
                    end
                end
                sms_pkg::SMS_HELD: begin
                    hold_stop_q <= 1'b0;
                    if (ctrl_q.resume && (dir_cw_out ? cw_ok : ccw_ok)) begin
                        state_q <= (remain_q == 32'h0 && !enc_mv_q) ? sms_pkg::SMS_IDLE
                                                                    : sms_pkg::SMS_RUN;
                    end
                end
                default: state_q <= sms_pkg::SMS_IDLE;
            endcase
        end
    end

    // Speed profile: start speed, ramp per step, clamp at both ends
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cur_spd_q <= 16'h0000;
            ramp_steps_q <= 32'h0;
        end else if (!moving) begin
            cur_spd_q <= start_q;
            ramp_steps_q <= 32'h0;
        end else if (step_tick) begin
            if (state_q == sms_pkg::SMS_DECEL) begin
                cur_spd_q <= (cur_spd_q - start_q > decel_q) ? cur_spd_q - decel_q : start_q;
            end else if (cur_spd_q < speed_q) begin
                cur_spd_q <= (speed_q - cur_spd_q > accel_q) ? cur_spd_q + accel_q : speed_q;
                ramp_steps_q <= ramp_steps_q + 32'h1;
            end
        end
    end

    // Phase accumulator and step pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 24'h000000;
            step_out <= 1'b0;
        end else begin
            phase_q <= moving ? phase_sum[`SMS_ACC_W-1:0] : 24'h000000;
            step_out <= step_tick;
        end
    end

    // Registration travel and latched stop input
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            travel_q <= 32'h0;
            stop_pend_q <= 1'b0;
        end else if (state_q == sms_pkg::SMS_IDLE) begin
            travel_q <= 32'h0;
            stop_pend_q <= reg_rise & mstop_lvl;
        end else begin
            if (step_tick) begin
                travel_q <= travel_q + 32'h1;
            end
            if (mstop_rise) begin
                stop_pend_q <= 1'b1;
            end
        end
    end

    // Position, validity, locks and refusal flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pos_q <= 32'h0;
            pos_valid_q <= 1'b0;
            cw_lock_q <= 1'b0;
            ccw_lock_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (wr_take && address == `SMS_OFF_POS) begin
                pos_q <= writedata;
                pos_valid_q <= 1'b1;
            end else begin
                if (step_tick) begin
                    pos_q <= dir_cw_out ? pos_q + 32'h1 : pos_q - 32'h1;
                end
                if (halt_now) begin
                    pos_valid_q <= 1'b0;
                end
            end
            // Lock set wins over a simultaneous reset
            if (ctrl_q.err_reset) begin
                cw_lock_q <= 1'b0;
                ccw_lock_q <= 1'b0;
                refused_q <= 1'b0;
            end
            if (lim_hit && dir_cw_out) begin
                cw_lock_q <= 1'b1;
            end
            if (lim_hit && !dir_cw_out) begin
                ccw_lock_q <= 1'b1;
            end
            if (state_q == sms_pkg::SMS_IDLE && ctrl_q.abs_go && !abs_ok) begin
                refused_q <= 1'b1;
            end
        end
    end

    // Encoder counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            enc_q <= 32'h0;
            enc_prev_q <= 2'b00;
        end else begin
            enc_prev_q <= pin_s_q[5:4];
            if (enc_tick) begin
                enc_q <= (pin_s_q[4] ^ pin_s_q[5]) ? enc_q + 32'h1 : enc_q - 32'h1;
            end
        end
    end

    // Read data, registered before the completing edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0;
        end else if (read && !ack_q) begin
            case (address)
                `SMS_OFF_CTRL: readdata <= {22'h0, ctrl_q};
                `SMS_OFF_STATUS: readdata <= {20'h0, refused_q, ccw_lock_q, cw_lock_q,
                                              pos_valid_q, dir_cw_out, enc_mv_q,
                                              kind_q, 2'b00, state_q};
                `SMS_OFF_TARGET: readdata <= target_q;
                `SMS_OFF_SPEED: readdata <= {16'h0, speed_q};
                `SMS_OFF_START: readdata <= {16'h0, start_q};
                `SMS_OFF_ACCEL: readdata <= {16'h0, accel_q};
                `SMS_OFF_DECEL: readdata <= {16'h0, decel_q};
                `SMS_OFF_REGSTEPS: readdata <= regsteps_q;
                `SMS_OFF_MINREG: readdata <= minreg_q;
                `SMS_OFF_POS: readdata <= pos_q;
                `SMS_OFF_ENC: readdata <= enc_q;
                default: readdata <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- sms_motor_model.sv
// Purpose: Shaft encoder of the motor driven by the sequencer
// Assumes: One quadrature state per step pulse
// Notes: Channels follow the step and direction outputs
`timescale 1ns/1ns
`default_nettype none
module sms_motor_model (
    input wire logic sys_clk,    // Clock
    input wire logic step_out,   // Step pulse from the sequencer
    input wire logic dir_cw_out, // Direction, high for clockwise
    output logic enc_a_in,       // Channel A
    output logic enc_b_in        // Channel B
);
    logic [1:0] ph_q = 2'h0;
    // Gray phase moves one state per step
    always_ff @(posedge sys_clk) begin
        if (step_out) ph_q <= dir_cw_out ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    // Channel A leads B when turning clockwise, so the count rises
    assign enc_a_in = ph_q[1] ^ ph_q[0];
    assign enc_b_in = ph_q[1];
endmodule
`default_nettype wire

//--- sms_sequencer_properties.sv
// Purpose: Concurrent checks on the sequencer ports
// Assumes: Pins reach the logic within four edges
// Notes: Bound to every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module sms_sequencer_checker (
    input wire logic sys_clk,        // Clock
    input wire logic resetn,         // Async reset, active low
    input wire logic read,           // Bus read
    input wire logic write,          // Bus write
    input wire logic [31:0] readdata, // Bus read data
    input wire logic waitrequest,    // Bus wait
    input wire logic estop_in,       // E-stop pin
    input wire logic cw_lim_in,      // Clockwise limit
    input wire logic ccw_lim_in,     // Counter-clockwise limit
    input wire logic step_out,       // Step pulse
    input wire logic dir_cw_out      // Direction
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_wait_once: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
        else $error("bus wait is not one cycle");
    a_wait_idle: assert property (!(read | write) |-> !waitrequest)
        else $error("wait without a request");
    a_rdata_hold: assert property (!read |=> $stable(readdata))
        else $error("read data moved without a read");
    a_step_gap: assert property (step_out |=> !step_out [*8])
        else $error("steps closer than the top rate");
    a_estop_halt: assert property ($rose(estop_in) |-> ##5 !step_out [*8])
        else $error("steps after e-stop");
    a_cw_limit: assert property ($rose(cw_lim_in) && dir_cw_out |-> ##5 !step_out [*8])
        else $error("steps after clockwise limit");
    a_ccw_limit: assert property ($rose(ccw_lim_in) && !dir_cw_out |-> ##5 !step_out [*8])
        else $error("steps after counter-clockwise limit");
    a_dir_steady: assert property (step_out |-> $stable(dir_cw_out))
        else $error("direction changed on a step");
endmodule
bind sms_sequencer sms_sequencer_checker sms_sequencer_checker_i (.sys_clk, .resetn, .read,
    .write, .readdata, .waitrequest, .estop_in, .cw_lim_in, .ccw_lim_in, .step_out, .dir_cw_out);
`default_nettype wire

//--- testbench.sv
// Purpose: Register-driven move tests of the sequencer
// Assumes: Step counts taken from the step pulse
// Notes: Speeds set high so moves stay short
`include "sms_map.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd, enc0;
    logic waitrequest, estop_in = 1'b0, mstop_in = 1'b0, cw_lim_in = 1'b0, ccw_lim_in = 1'b0;
    logic enc_a_in, enc_b_in, step_out, dir_cw_out;
    int n_fail = 0, checks = 0, nstep = 0, base = 0;
    sms_sequencer sms_sequencer_i (.sys_clk, .resetn, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .estop_in, .mstop_in, .cw_lim_in, .ccw_lim_in, .enc_a_in,
        .enc_b_in, .step_out, .dir_cw_out);
    sms_motor_model sms_motor_model_i (.sys_clk, .step_out, .dir_cw_out, .enc_a_in, .enc_b_in);
    initial forever #10 sys_clk = ~sys_clk;
    // Step counter
    always @(posedge sys_clk) if (step_out) nstep <= nstep + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge sys_clk); while (waitrequest);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_st(input logic [1:0] s);
        do bus(1'b0, 6'h04, 32'h0); while (rd[1:0] !== s);
    endtask
    task automatic go(input logic [31:0] tgt, input logic [31:0] ctl);
        base = nstep;
        bus(1'b1, 6'h08, tgt);
        bus(1'b1, 6'h00, ctl);
    endtask
    task automatic move(input logic [31:0] tgt, input logic [31:0] ctl, input int n);
        go(tgt, ctl);
        wait_st(2'h0);
        check(nstep - base, n);
    endtask
    task automatic test_done();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1800000;
        n_fail++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, 6'h0c, 32'h0);
        check(rd, `SMS_RST_SPEED);
        bus(1'b0, 6'h10, 32'h0);
        check(rd, `SMS_RST_START);
        bus(1'b0, 6'h3c, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 6'h10, 32'h8000);
        bus(1'b1, 6'h0c, 32'hffff);
        bus(1'b1, 6'h14, 32'h1000);
        bus(1'b1, 6'h18, 32'h1000);
        move(32'h5, 32'h2, 5);
        check(dir_cw_out, 1'b1);
        move(-32'sd3, 32'h2, 3);
        check(dir_cw_out, 1'b0);
        move(32'h2, 32'h4, 0);
        check(rd[11], 1'b1);
        bus(1'b1, 6'h24, 32'ha);
        move(32'h7, 32'h4, 3);
        check(dir_cw_out, 1'b0);
        bus(1'b0, 6'h24, 32'h0);
        check(rd, 32'h7);
        bus(1'b1, 6'h20, 32'h2);
        bus(1'b1, 6'h1c, 32'h3);
        go(32'h0, 32'h201);
        wait (nstep - base == 4);
        move(32'h0, 32'h200, 3);
        mstop_in <= 1'b1;
        move(32'h0, 32'h201, 5);
        mstop_in <= 1'b0;
        go(32'd40, 32'h2);
        wait (nstep - base == 3);
        estop_in <= 1'b1;
        wait_st(2'h0);
        check(nstep - base, 3);
        check(rd[8], 1'b0);
        estop_in <= 1'b0;
        go(32'd40, 32'h2);
        wait (nstep - base == 2);
        cw_lim_in <= 1'b1;
        wait_st(2'h0);
        check(rd[9], 1'b1);
        move(32'h5, 32'h2, 0);
        move(-32'sd2, 32'h2, 2);
        cw_lim_in <= 1'b0;
        move(32'h1, 32'h2, 0);
        bus(1'b1, 6'h00, 32'h40);
        move(32'h1, 32'h2, 1);
        go(32'd20, 32'h2);
        wait (nstep - base == 3);
        bus(1'b1, 6'h00, 32'h8);
        wait_st(2'h3);
        bus(1'b1, 6'h00, 32'h18);
        wait_st(2'h0);
        check(nstep - base, 20);
        bus(1'b0, 6'h28, 32'h0);
        enc0 = rd;
        move(32'h2, 32'h102, 8);
        bus(1'b0, 6'h28, 32'h0);
        check(rd - enc0, 32'h4);
        go(32'h0, 32'h201);
        wait (nstep - base == 3);
        bus(1'b1, 6'h00, 32'h209);
        wait_st(2'h0);
        check(nstep - base, 6);
        bus(1'b1, 6'h00, 32'h211);
        bus(1'b0, 6'h04, 32'h0);
        check(rd[1:0], 2'h0);
        bus(1'b1, 6'h24, 32'h0);
        go(32'h5, 32'h4);
        wait (nstep - base == 2);
        bus(1'b1, 6'h00, 32'h8);
        wait_st(2'h3);
        bus(1'b1, 6'h00, 32'h18);
        wait_st(2'h0);
        check(nstep - base, 5);
        bus(1'b0, 6'h24, 32'h0);
        check(rd, 32'h5);
        go(32'd40, 32'h2);
        wait (nstep - base == 2);
        bus(1'b1, 6'h00, 32'h20);
        wait_st(2'h0);
        check(nstep - base, 2);
        go(-32'sd40, 32'h2);
        wait (nstep - base == 2);
        ccw_lim_in <= 1'b1;
        wait_st(2'h0);
        check(nstep - base, 2);
        check(rd[10], 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
